// File: hw/pjs_pkg.sv
// Shared constants and types for the programmed jog sequencer
package pjs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_WPROT = 8'h00;
  localparam logic [7:0] OFS_PATTERN = 8'h04;
  localparam logic [7:0] OFS_DIST = 8'h08;
  localparam logic [7:0] OFS_SPEED = 8'h0c;
  localparam logic [7:0] OFS_RAMP = 8'h10;
  localparam logic [7:0] OFS_WAIT = 8'h14;
  localparam logic [7:0] OFS_REPEAT = 8'h18;
  localparam logic [7:0] OFS_DIRSEL = 8'h1c;
  localparam logic [7:0] OFS_KEY = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_POS = 8'h28;
  localparam logic [7:0] OFS_FILT = 8'h2c;
  // Write-protect code that permits operation, and its value after reset
  localparam logic [15:0] WPROT_PERMIT = 16'h0000;
  localparam logic [15:0] WPROT_RST = 16'h0000;
  // Setting limits and values after reset
  localparam logic [31:0] PAT_MIN = 32'h0000_0000;
  localparam logic [31:0] PAT_MAX = 32'h0000_0005;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;
  localparam logic [31:0] DIST_MIN = 32'h0000_0001;
  localparam logic [31:0] DIST_MAX = 32'h4000_0000;
  localparam logic [31:0] DIST_RST = 32'h0000_8000;
  localparam logic [31:0] SPEED_MIN = 32'h0000_0001;
  localparam logic [31:0] SPEED_MAX = 32'h0000_2710;
  localparam logic [31:0] SPEED_RST = 32'h0000_0032;
  localparam logic [31:0] RAMP_MIN = 32'h0000_0002;
  localparam logic [31:0] RAMP_MAX = 32'h0000_2710;
  localparam logic [31:0] RAMP_RST = 32'h0000_0064;
  localparam logic [31:0] WAIT_MIN = 32'h0000_0000;
  localparam logic [31:0] WAIT_MAX = 32'h0000_2710;
  localparam logic [31:0] WAIT_RST = 32'h0000_0064;
  localparam logic [31:0] REP_MIN = 32'h0000_0000;
  localparam logic [31:0] REP_MAX = 32'h0000_03e8;
  localparam logic [31:0] REP_RST = 32'h0000_0001;
  // Key register bit positions
  localparam int KEY_SERVO = 0;
  localparam int KEY_FWD = 1;
  localparam int KEY_REV = 2;
  localparam int KEY_EXIT = 3;
  localparam int KEY_ENTER = 4;
  localparam int KEY_CLEAR = 7;
  // Status register bit positions
  localparam int ST_MOTOR_BIT = 8;
  localparam int ST_END_BIT = 9;
  localparam int ST_REFUSED_BIT = 10;
  localparam int ST_RANGE_BIT = 11;
  localparam int ST_OT_BIT = 12;
  localparam int ST_IDX_LSB = 16;
  // Timing: clock period, one millisecond, completion display time
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int END_TIME_MS = 1000;
  localparam logic [13:0] END_MS_LAST = 14'(END_TIME_MS - 1);
  // Condition pins from the drive
  typedef struct packed {
    logic mainPowerOk;
    logic alarmActive;
    logic hardBlockActive;
    logic otFwd;
    logic otRev;
  } pjs_pins_t;
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_BASEBLOCK = 6'h02,
    ST_RUN = 6'h04,
    ST_WAIT = 6'h08,
    ST_MOVE = 6'h10,
    ST_END = 6'h20
  } pjs_state_t;
endpackage

// File: hw/pjs_program_jog.sv
// Programmed jog sequencer with Avalon-MM register slave
//
// Contract
// - Start refused unless writes are permitted
// - Start needs power, no alarm, no overtravel
// - Overtravel stops motion while running
// - Repeat count zero repeats the pattern forever
// - Patterns two and three never start endless
// - Pattern codes zero to five, reset zero
// - Distance one to 2^30, reset 32768
// - Speed one to 10000, reset 50
// - Ramp time two to 10000 ms, reset 100
// - Wait time zero to 10000 ms, reset 100
// - Repeat count zero to 1000, reset one
// - Servo key energizes motor from baseblock
// - First move starts after the wait time
// - Servo key again stops and baseblocks
// - Completion shown one second, then run
// - Exit key baseblocks and leaves the function
// - Direction zero: forward counts position up
// - Reference filter stays applied to motion
`timescale 1ns/1ps
module pjs_program_jog #(
  parameter int MS_CYCLES = pjs_pkg::CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pjs_pkg::pjs_pins_t pinsIn,
  output logic motorPowerOn,
  output logic fnActive,
  output logic runInd,
  output logic endInd,
  output logic [31:0] refPos
);
  localparam int MSW = $clog2(MS_CYCLES + 1);

  pjs_pkg::pjs_pins_t pinsMetaQ, pinsQ;
  pjs_pkg::pjs_state_t stateQ, stateD;
  logic ackQ, wrEn, wrValid;
  logic [7:0] keys;
  logic servoKey, fwdKey, revKey, exitKey, enterKey, clearKey;
  logic [15:0] wprotQ;
  logic [2:0] patQ;
  logic [30:0] distQ;
  logic [13:0] speedQ, rampQ, waitQ;
  logic [9:0] repQ;
  logic dirSelQ;
  logic [3:0] filtShiftQ;
  logic refusedQ, rangeErrQ, otStopQ, refuseSet, otStopEv;
  logic startOk, faultNow, patTwoThree, endlessBad, startKeyOk, moveFwd, otHit;
  logic [MSW-1:0] msCntQ;
  logic tick;
  logic [13:0] phaseMsQ;
  logic [10:0] moveIdxQ, totalMoves;
  logic lastMove, moveDone;
  logic [13:0] velQ;
  logic [14:0] fracQ;
  logic [30:0] coveredQ, accDistQ, remain, step, remainAfter, coveredNext;
  logic decelQ;
  logic [31:0] rawPosQ, filtQ, diff, rdValue;

  // Range check shared by the pattern, distance, speed, ramp, wait and repeat writes
  function automatic logic inRange(input logic [31:0] v, input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Pattern direction of a move: 1 means forward
  function automatic logic dirOf(input logic [2:0] pat, input logic [10:0] idx,
                                 input logic [9:0] reps);
    logic firstHalf;
    // An endless split pattern is refused later, but its first move still has a direction
    firstHalf = (reps == 10'h000) || (idx < {1'b0, reps});
    case (pat)
      3'h0: dirOf = 1'b1;
      3'h1: dirOf = 1'b0;
      3'h2: dirOf = firstHalf;
      3'h3: dirOf = ~firstHalf;
      3'h4: dirOf = ~idx[0];
      3'h5: dirOf = idx[0];
      default: dirOf = 1'b1;
    endcase
  endfunction

  // Pins come from outside; only the second stage is read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinsMetaQ <= '0;
      pinsQ <= '0;
    end else begin
      pinsMetaQ <= pinsIn;
      pinsQ <= pinsMetaQ;
    end
  end

  // One wait state per access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ackQ;
  assign wrEn = avs_write & ackQ;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= (avs_read | avs_write) & ~ackQ;
    end
  end

  // Key presses are single-cycle strobes from the key register
  assign keys = (wrEn && avs_address == pjs_pkg::OFS_KEY) ? avs_writedata[7:0] : 8'h00;
  assign servoKey = keys[pjs_pkg::KEY_SERVO];
  assign fwdKey = keys[pjs_pkg::KEY_FWD];
  assign revKey = keys[pjs_pkg::KEY_REV];
  assign exitKey = keys[pjs_pkg::KEY_EXIT];
  assign enterKey = keys[pjs_pkg::KEY_ENTER];
  assign clearKey = keys[pjs_pkg::KEY_CLEAR];

  // Out-of-range values are dropped so the stored setting stays legal
  // setting limits
  always_comb begin
    unique case (avs_address)
      pjs_pkg::OFS_PATTERN: wrValid = inRange(avs_writedata, pjs_pkg::PAT_MIN, pjs_pkg::PAT_MAX);
      pjs_pkg::OFS_DIST: wrValid = inRange(avs_writedata, pjs_pkg::DIST_MIN, pjs_pkg::DIST_MAX);
      pjs_pkg::OFS_SPEED: wrValid = inRange(avs_writedata, pjs_pkg::SPEED_MIN, pjs_pkg::SPEED_MAX);
      pjs_pkg::OFS_RAMP: wrValid = inRange(avs_writedata, pjs_pkg::RAMP_MIN, pjs_pkg::RAMP_MAX);
      pjs_pkg::OFS_WAIT: wrValid = inRange(avs_writedata, pjs_pkg::WAIT_MIN, pjs_pkg::WAIT_MAX);
      pjs_pkg::OFS_REPEAT: wrValid = inRange(avs_writedata, pjs_pkg::REP_MIN, pjs_pkg::REP_MAX);
      default: wrValid = 1'b1;
    endcase
  end

  // Settings take effect at once; no lock while running
  // setting store
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wprotQ <= pjs_pkg::WPROT_RST;
      patQ <= pjs_pkg::PAT_RST[2:0];
      distQ <= pjs_pkg::DIST_RST[30:0];
      speedQ <= pjs_pkg::SPEED_RST[13:0];
      rampQ <= pjs_pkg::RAMP_RST[13:0];
      waitQ <= pjs_pkg::WAIT_RST[13:0];
      repQ <= pjs_pkg::REP_RST[9:0];
      dirSelQ <= 1'b0;
      filtShiftQ <= 4'h0;
    end else if (wrEn && wrValid) begin
      unique case (avs_address)
        pjs_pkg::OFS_WPROT: wprotQ <= avs_writedata[15:0];
        pjs_pkg::OFS_PATTERN: patQ <= avs_writedata[2:0];
        pjs_pkg::OFS_DIST: distQ <= avs_writedata[30:0];
        pjs_pkg::OFS_SPEED: speedQ <= avs_writedata[13:0];
        pjs_pkg::OFS_RAMP: rampQ <= avs_writedata[13:0];
        pjs_pkg::OFS_WAIT: waitQ <= avs_writedata[13:0];
        pjs_pkg::OFS_REPEAT: repQ <= avs_writedata[9:0];
        pjs_pkg::OFS_DIRSEL: dirSelQ <= avs_writedata[0];
        pjs_pkg::OFS_FILT: filtShiftQ <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  // Start conditions and faults
  // write permission checked
  assign startOk = (wprotQ == pjs_pkg::WPROT_PERMIT) && pinsQ.mainPowerOk &&
                   !pinsQ.alarmActive && !pinsQ.hardBlockActive && !pinsQ.otFwd && !pinsQ.otRev;
  assign faultNow = !pinsQ.mainPowerOk || pinsQ.alarmActive || pinsQ.hardBlockActive;
  assign patTwoThree = (patQ == 3'h2) || (patQ == 3'h3);
  assign endlessBad = (repQ == 10'h000) && patTwoThree;
  // Start key must match the first move direction
  assign startKeyOk = (fwdKey && dirOf(patQ, 11'h000, repQ)) ||
                      (revKey && !dirOf(patQ, 11'h000, repQ));
  assign moveFwd = dirOf(patQ, moveIdxQ, repQ);
  assign otHit = moveFwd ? pinsQ.otFwd : pinsQ.otRev;
  assign totalMoves = patTwoThree ? {repQ, 1'b0} : {1'b0, repQ};
  assign lastMove = (repQ != 10'h000) && (moveIdxQ + 11'h001 == totalMoves);

  // Millisecond base, restarted on every state change
  assign tick = msCntQ == MSW'(MS_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      msCntQ <= '0;
      phaseMsQ <= 14'h0000;
    end else if (stateD != stateQ) begin
      msCntQ <= '0;
      phaseMsQ <= 14'h0000;
    end else begin
      msCntQ <= tick ? '0 : msCntQ + MSW'(1);
      phaseMsQ <= tick ? phaseMsQ + 14'h0001 : phaseMsQ;
    end
  end

  // Next state; servo key, faults and exit override the sequence
  always_comb begin
    stateD = stateQ;
    refuseSet = 1'b0;
    otStopEv = 1'b0;
    unique case (stateQ)
      pjs_pkg::ST_OFF: begin
        if (enterKey) begin
          stateD = startOk ? pjs_pkg::ST_BASEBLOCK : pjs_pkg::ST_OFF;
          refuseSet = !startOk;
        end
      end
      pjs_pkg::ST_BASEBLOCK: begin
        if (servoKey) begin
          stateD = startOk ? pjs_pkg::ST_RUN : pjs_pkg::ST_BASEBLOCK;
          refuseSet = !startOk;
        end
      end
      pjs_pkg::ST_RUN: begin
        if (startKeyOk) begin
          stateD = endlessBad ? pjs_pkg::ST_RUN : pjs_pkg::ST_WAIT;
          refuseSet = endlessBad;
        end
      end
      pjs_pkg::ST_WAIT: begin
        if (tick && ({1'b0, phaseMsQ} + 15'h0001 >= {1'b0, waitQ})) begin
          stateD = pjs_pkg::ST_MOVE;
        end
      end
      pjs_pkg::ST_MOVE: begin
        if (otHit) begin
          stateD = pjs_pkg::ST_RUN;
          otStopEv = 1'b1;
        end else if (moveDone) begin
          stateD = lastMove ? pjs_pkg::ST_END : pjs_pkg::ST_WAIT;
        end
      end
      pjs_pkg::ST_END: begin
        if (tick && phaseMsQ == pjs_pkg::END_MS_LAST) begin
          stateD = pjs_pkg::ST_RUN;
        end
      end
    endcase
    if (motorPowerOn && (servoKey || faultNow)) begin
      stateD = pjs_pkg::ST_BASEBLOCK;
    end
    if (exitKey) begin
      stateD = pjs_pkg::ST_OFF;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stateQ <= pjs_pkg::ST_OFF;
    end else begin
      stateQ <= stateD;
    end
  end

  // Move index; reset on each start key, advanced per finished move except the last
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      moveIdxQ <= 11'h000;
    end else if (stateQ == pjs_pkg::ST_RUN && stateD == pjs_pkg::ST_WAIT) begin
      moveIdxQ <= 11'h000;
    end else if (stateQ == pjs_pkg::ST_MOVE && stateD == pjs_pkg::ST_WAIT) begin
      moveIdxQ <= moveIdxQ + 11'h001;
    end
  end

  // Step per millisecond, clamped so the move lands on the distance
  assign remain = (coveredQ >= distQ) ? 31'h0 : distQ - coveredQ;
  assign step = ({17'h0, velQ} > remain) ? remain : {17'h0, velQ};
  assign remainAfter = remain - step;
  assign coveredNext = coveredQ + step;
  assign moveDone = tick && (coveredNext >= distQ);

  // trapezoid: ramp, cruise, mirrored decel
  // Speed steps come from a fraction drained by the ramp time per clock, avoiding a divider
  always_ff @(posedge clk) begin
    if (!rst_n || stateQ != pjs_pkg::ST_MOVE) begin
      velQ <= 14'h0000;
      fracQ <= 15'h0000;
      coveredQ <= 31'h0;
      accDistQ <= 31'h0;
      decelQ <= 1'b0;
    end else if (tick) begin
      coveredQ <= coveredNext;
      if (!decelQ) begin
        if (velQ < speedQ) begin
          accDistQ <= coveredNext;
        end
        if (remainAfter <= accDistQ || {coveredNext, 1'b0} >= {1'b0, distQ}) begin
          decelQ <= 1'b1;
          fracQ <= 15'h0000;
        end else if (velQ < speedQ) begin
          fracQ <= fracQ + {1'b0, speedQ};
        end
      end else begin
        fracQ <= fracQ + {1'b0, speedQ};
      end
    end else if (fracQ >= {1'b0, rampQ}) begin
      fracQ <= fracQ - {1'b0, rampQ};
      if (!decelQ && velQ < speedQ) begin
        velQ <= velQ + 14'h0001;
      end else if (decelQ && velQ > 14'h0001) begin
        velQ <= velQ - 14'h0001;
      end
    end
  end

  // reference passes the filter
  // Shift zero bypasses the filter; wide shifts give slow, smooth approach
  assign diff = rawPosQ - filtQ;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rawPosQ <= 32'h0000_0000;
      filtQ <= 32'h0000_0000;
    end else begin
      if (stateQ == pjs_pkg::ST_MOVE && tick) begin
        rawPosQ <= (moveFwd ^ dirSelQ) ? rawPosQ + {1'b0, step} : rawPosQ - {1'b0, step};
      end
      filtQ <= filtQ + 32'($signed(diff) >>> filtShiftQ);
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refusedQ <= 1'b0;
      rangeErrQ <= 1'b0;
      otStopQ <= 1'b0;
    end else begin
      refusedQ <= refuseSet | (refusedQ & ~clearKey);
      rangeErrQ <= (wrEn & ~wrValid) | (rangeErrQ & ~clearKey);
      otStopQ <= otStopEv | (otStopQ & ~clearKey);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdValue = 32'h0000_0000;
    unique case (avs_address)
      pjs_pkg::OFS_WPROT: rdValue = {16'h0000, wprotQ};
      pjs_pkg::OFS_PATTERN: rdValue = {29'h0, patQ};
      pjs_pkg::OFS_DIST: rdValue = {1'b0, distQ};
      pjs_pkg::OFS_SPEED: rdValue = {18'h0, speedQ};
      pjs_pkg::OFS_RAMP: rdValue = {18'h0, rampQ};
      pjs_pkg::OFS_WAIT: rdValue = {18'h0, waitQ};
      pjs_pkg::OFS_REPEAT: rdValue = {22'h0, repQ};
      pjs_pkg::OFS_DIRSEL: rdValue = {31'h0, dirSelQ};
      pjs_pkg::OFS_FILT: rdValue = {28'h0, filtShiftQ};
      pjs_pkg::OFS_POS: rdValue = filtQ;
      pjs_pkg::OFS_STATUS: begin
        rdValue[5:0] = stateQ;
        rdValue[pjs_pkg::ST_MOTOR_BIT] = motorPowerOn;
        rdValue[pjs_pkg::ST_END_BIT] = endInd;
        rdValue[pjs_pkg::ST_REFUSED_BIT] = refusedQ;
        rdValue[pjs_pkg::ST_RANGE_BIT] = rangeErrQ;
        rdValue[pjs_pkg::ST_OT_BIT] = otStopQ;
        rdValue[pjs_pkg::ST_IDX_LSB +: 11] = moveIdxQ;
      end
      default: ;
    endcase
  end

  // Read data captured in the wait cycle, held through the answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ackQ) begin
      avs_readdata <= rdValue;
    end
  end

  // Outputs decoded from the state register; refPos follows the filter
  assign motorPowerOn = stateQ inside {pjs_pkg::ST_RUN, pjs_pkg::ST_WAIT,
                                       pjs_pkg::ST_MOVE, pjs_pkg::ST_END};
  assign fnActive = stateQ != pjs_pkg::ST_OFF;
  assign endInd = stateQ == pjs_pkg::ST_END;
  assign runInd = motorPowerOn && !endInd;
  assign refPos = filtQ;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  write_protect_a: assert property (
    ((stateQ == pjs_pkg::ST_OFF && enterKey) || (stateQ == pjs_pkg::ST_BASEBLOCK && servoKey)) &&
    wprotQ != pjs_pkg::WPROT_PERMIT
    |=> !motorPowerOn && refusedQ) else $error("start allowed while write protected");
  start_cond_a: assert property (
    ((stateQ == pjs_pkg::ST_OFF && enterKey) || (stateQ == pjs_pkg::ST_BASEBLOCK && servoKey)) &&
    faultNow |=> !motorPowerOn && refusedQ)
    else $error("start allowed with drive fault");
  ot_stop_a: assert property (
    stateQ == pjs_pkg::ST_MOVE && otHit && !exitKey |=> stateQ == pjs_pkg::ST_RUN && otStopQ)
    else $error("motion kept at travel limit");
  endless_run_a: assert property (
    stateQ == pjs_pkg::ST_MOVE && repQ == 10'h000 |=> stateQ != pjs_pkg::ST_END)
    else $error("zero repeat count ended run");
  no_endless_a: assert property (
    stateQ == pjs_pkg::ST_RUN && startKeyOk && endlessBad |=> stateQ != pjs_pkg::ST_WAIT)
    else $error("endless run started for two-way pattern");
  setting_range_a: assert property (
    patQ <= 3'h5 && distQ != 31'h0 && distQ <= pjs_pkg::DIST_MAX[30:0] &&
    speedQ != 14'h0000 && speedQ <= pjs_pkg::SPEED_MAX[13:0] &&
    rampQ >= pjs_pkg::RAMP_MIN[13:0] && rampQ <= pjs_pkg::RAMP_MAX[13:0] &&
    waitQ <= pjs_pkg::WAIT_MAX[13:0] && repQ <= pjs_pkg::REP_MAX[9:0])
    else $error("setting out of range");
  servo_on_a: assert property (
    stateQ == pjs_pkg::ST_BASEBLOCK && servoKey && startOk && !exitKey
    |=> motorPowerOn && runInd) else $error("servo key did not energize");
  wait_first_a: assert property (
    stateQ == pjs_pkg::ST_WAIT ##1 stateQ == pjs_pkg::ST_MOVE
    |-> $past(phaseMsQ) + 14'h0001 >= waitQ) else $error("move began before wait elapsed");
  servo_stop_a: assert property (
    motorPowerOn && servoKey && !exitKey |=> stateQ == pjs_pkg::ST_BASEBLOCK ##1 velQ == 14'h0000)
    else $error("servo key did not stop motion");
  end_hold_a: assert property (
    stateQ == pjs_pkg::ST_END ##1 stateQ == pjs_pkg::ST_RUN
    |-> $past(phaseMsQ) == pjs_pkg::END_MS_LAST) else $error("completion shown wrong time");
  exit_fn_a: assert property (
    exitKey |=> stateQ == pjs_pkg::ST_OFF && !motorPowerOn) else $error("exit key ignored");
  dir_sense_a: assert property (
    stateQ == pjs_pkg::ST_MOVE && tick && step != 31'h0 && moveFwd && !dirSelQ
    |=> $signed(rawPosQ - $past(rawPosQ)) > 0) else $error("forward move did not count up");
  filter_bypass_a: assert property (
    filtShiftQ == 4'h0 |=> filtQ == $past(rawPosQ)) else $error("filter output wrong");
  trapezoid_a: assert property (
    stateQ == pjs_pkg::ST_MOVE |-> coveredQ <= distQ && (decelQ || velQ <= speedQ))
    else $error("profile overshoot");
endmodule // pjs_program_jog

// File: bench/pjs_drive_model.sv
// Drive-side model: main power, alarm and a travel limit switch on the scale
`timescale 1ns/1ps
module pjs_drive_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic alarmReq,
  input wire logic limitEn,
  input wire logic [31:0] limitPos,
  input wire logic [31:0] refPos,
  output pjs_pkg::pjs_pins_t pins
);
  // Registered like a real sensor, so the sequencer sees every pin change late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins <= '0;
    end else begin
      pins.mainPowerOk <= 1'b1;
      pins.alarmActive <= alarmReq;
      pins.hardBlockActive <= 1'b0;
      pins.otFwd <= limitEn && ($signed(refPos) >= $signed(limitPos));
      pins.otRev <= 1'b0;
    end
  end
endmodule // pjs_drive_model

// File: bench/pjs_program_jog_test.sv
// Self-checking bench for the programmed jog sequencer
`timescale 1ns/1ps
module pjs_program_jog_test;
  localparam int MSC = 20;
  localparam logic [7:0] STA = pjs_pkg::OFS_STATUS;
  logic clk, rst_n, rdReq, wrReq, alarmReq, limitEn, motorOn, fnAct, runInd, endInd, waitReq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, refPos, limitPos, q;
  pjs_pkg::pjs_pins_t pins;
  int errCount, nTests, cyc, n;
  logic [31:0] rstV [6] = '{32'h0, 32'h8000, 32'h32, 32'h64, 32'h64, 32'h1};
  logic [31:0] badV [6] = '{32'h6, 32'h0, 32'h2711, 32'h1, 32'h2711, 32'h3e9};
  logic [31:0] maxV [6] = '{32'h5, 32'h4000_0000, 32'h2710, 32'h2710, 32'h2710, 32'h3e8};
  logic [31:0] runV [6] = '{32'h0, 32'h8, 32'h4, 32'h2, 32'h3, 32'h1};
  // Short ms so the one-second completion display stays affordable
  pjs_program_jog #(.MS_CYCLES(MSC)) uut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rdReq), .avs_write(wrReq), .avs_writedata(wdat), .avs_readdata(rdat),
    .avs_waitrequest(waitReq), .pinsIn(pins), .motorPowerOn(motorOn), .fnActive(fnAct),
    .runInd(runInd), .endInd(endInd), .refPos(refPos));
  pjs_drive_model drive (.clk(clk), .rst_n(rst_n), .alarmReq(alarmReq), .limitEn(limitEn),
    .limitPos(limitPos), .refPos(refPos), .pins(pins));
  // Clock source
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic stopTest;
    if (errCount == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hang anywhere in the sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      errCount++;
      stopTest();
    end
  end
  // One bus cycle; request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wrReq <= w;
    rdReq <= !w;
    do @(posedge clk); while (waitReq !== 1'b0);
    q = rdat;
    wrReq <= 1'b0;
    rdReq <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    acc(1'b0, a, '0);
    chk(nm, e, q & m);
  endtask
  // Keys are one-shot bits of the key register
  task automatic key(input int b);
    acc(1'b1, pjs_pkg::OFS_KEY, 32'h1 << b);
  endtask
  // Poll the state field under a bounded count
  task automatic waitSt(input logic [31:0] s);
    n = 0;
    do begin
      acc(1'b0, STA, '0);
      n++;
    end while ((q & 32'h3f) !== s && n < 3000);
    chk("state", s, q & 32'h3f);
  endtask
  initial begin
    {rst_n, rdReq, wrReq, alarmReq, limitEn} = '0;
    adr = '0;
    wdat = '0;
    limitPos = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset value, refusal of an out-of-range value, acceptance of the maximum
    for (int i = 0; i < 6; i++) begin
      rchk("setting reset", 8'(4 * i + 4), '1, rstV[i]);
      acc(1'b1, 8'(4 * i + 4), badV[i]);
      rchk("setting kept", 8'(4 * i + 4), '1, rstV[i]);
      acc(1'b1, 8'(4 * i + 4), maxV[i]);
      rchk("setting max", 8'(4 * i + 4), '1, maxV[i]);
    end
    rchk("range flag", STA, 32'h800, 32'h800);
    acc(1'b1, pjs_pkg::OFS_WPROT, 32'h1);
    key(pjs_pkg::KEY_ENTER);
    rchk("protected entry", STA, 32'h43f, 32'h401);
    acc(1'b1, pjs_pkg::OFS_WPROT, 32'h0);
    key(pjs_pkg::KEY_CLEAR);
    alarmReq <= 1'b1;
    repeat (4) @(posedge clk);
    key(pjs_pkg::KEY_ENTER);
    rchk("alarm entry", STA, 32'h43f, 32'h401);
    alarmReq <= 1'b0;
    repeat (4) @(posedge clk);
    key(pjs_pkg::KEY_CLEAR);
    key(pjs_pkg::KEY_ENTER);
    rchk("entry", STA, 32'h43f, 32'h002);
    key(pjs_pkg::KEY_SERVO);
    rchk("servo on", STA, 32'h13f, 32'h104);
    chk("motor pin", 32'h1, 32'(motorOn));
    for (int i = 0; i < 6; i++) acc(1'b1, 8'(4 * i + 4), runV[i]);
    key(pjs_pkg::KEY_FWD);
    rchk("waiting", STA, 32'h3f, 32'h08);
    repeat (2 * MSC) @(posedge clk);
    chk("pos in wait", 32'h0, refPos);
    n = 0;
    while (endInd !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    // Filter output trails the last step by a clock, so let it settle
    repeat (2) @(posedge clk);
    chk("pos after move", 32'h8, refPos);
    n = 0;
    while (endInd === 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk("end time", 32'h1, 32'(n >= 999 * MSC && n <= 1001 * MSC));
    chk("run shown", 32'h1, 32'(runInd));
    // Split patterns may not run endless
    for (int p = 2; p < 4; p++) begin
      acc(1'b1, pjs_pkg::OFS_PATTERN, 32'(p));
      acc(1'b1, pjs_pkg::OFS_REPEAT, 32'h0);
      key(p == 2 ? pjs_pkg::KEY_FWD : pjs_pkg::KEY_REV);
      rchk("split endless", STA, 32'h43f, 32'h404);
      key(pjs_pkg::KEY_CLEAR);
    end
    acc(1'b1, pjs_pkg::OFS_PATTERN, 32'h0);
    key(pjs_pkg::KEY_FWD);
    repeat (40 * MSC) @(posedge clk);
    acc(1'b0, STA, '0);
    chk("endless run", 32'h1, 32'((q & 32'h18) != 0));
    chk("endless pos", 32'h1, 32'(refPos > 32'h18));
    key(pjs_pkg::KEY_SERVO);
    rchk("servo off", STA, 32'h13f, 32'h002);
    key(pjs_pkg::KEY_SERVO);
    key(pjs_pkg::KEY_FWD);
    waitSt(32'h10);
    limitPos <= refPos;
    limitEn <= 1'b1;
    repeat (6) @(posedge clk);
    rchk("overtravel", STA, 32'h103f, 32'h1004);
    limitEn <= 1'b0;
    // Direction select one: a forward pattern must count the position down
    acc(1'b1, pjs_pkg::OFS_DIRSEL, 32'h1);
    limitPos <= refPos;
    key(pjs_pkg::KEY_FWD);
    waitSt(32'h10);
    repeat (4 * MSC) @(posedge clk);
    chk("reverse count", 32'h1, 32'($signed(refPos) < $signed(limitPos)));
    key(pjs_pkg::KEY_EXIT);
    rchk("exit", STA, 32'h13f, 32'h001);
    chk("function left", 32'h0, 32'(fnAct));
    stopTest();
  end
endmodule // pjs_program_jog_test
